// File: logic/aiw_window.sv
// Purpose: Ancillary region placement registers, window compare, byte insertion
// Assumes: Timing strobes come from logic on clk_sys_i
// Notes:   Field select 0 = top field, 1 = bottom field
//
// Notes on behaviour
// - Each field holds 11-bit horizontal-region sizes
// - Bottom horizontal region starts at programmed line
// - Bottom horizontal region starts at programmed pixel
// - Top vertical region starts at programmed line
// - Top vertical region starts at programmed pixel
// - Reserved bits read zero; fields reset zero
// - Separate top/bottom settings, applied per field
// - Top horizontal region start line and pixel
// - Top vertical region holds line/pixel sizes
`timescale 1ns/1ps
`default_nettype none
`include "aiw_consts.svh"

// ----------------------------------------
// Ancillary byte FIFO
// ----------------------------------------
module aiw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [CW-1:0]               count;
    } aiw_fifo_state_type;

    aiw_fifo_state_type st_r;
    aiw_fifo_state_type st_nxt;
    logic               push;
    logic               pop;

    assign in_ready_o  = (st_r.count != CW'(DEPTH));
    assign out_valid_o = (st_r.count != '0);
    assign out_data_o  = st_r.mem[st_r.rptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_ready_i && out_valid_o;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wptr] = in_data_i;
            st_nxt.wptr = (st_r.wptr == AW'(DEPTH - 1)) ? '0 : st_r.wptr + 1'b1;
        end
        if (pop) begin
            st_nxt.rptr = (st_r.rptr == AW'(DEPTH - 1)) ? '0 : st_r.rptr + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.count = st_r.count + 1'b1;
        end else if (pop && !push) begin
            st_nxt.count = st_r.count - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ----------------------------------------
// Top: registers, counters, insertion
// ----------------------------------------
module aiw_window (
    input  wire logic                   clk_sys_i,
    input  wire logic                   reset_i,
    input  wire logic [`AIW_ADDR_W-1:0] reg_addr_i,
    input  wire logic [31:0]            reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [31:0]            reg_rdata_o,
    input  wire logic                   frame_start_i,
    input  wire logic                   line_start_i,
    input  wire logic                   pix_adv_i,
    input  wire logic                   field_i,
    input  wire logic [7:0]             video_data_i,
    input  wire logic [7:0]             anc_data_i,
    input  wire logic                   anc_valid_i,
    output logic                        anc_ready_o,
    output logic      [7:0]             out_data_o,
    output logic                        out_valid_o,
    output logic                        out_anc_o
);
    aiw_pkg::aiw_state_type st_r;
    aiw_pkg::aiw_state_type st_nxt;

    logic [7:0] fifo_data;
    logic       fifo_valid;
    logic       fifo_pop;
    logic       top_h_hit;
    logic       bot_h_hit;
    logic       top_v_hit;
    logic       in_region;

    // Rectangle test in 12 bits so start + size cannot wrap
    function automatic logic inside_win(input logic [10:0] pos,
                                        input logic [10:0] start,
                                        input logic [10:0] size);
        logic [11:0] end_pos;
        end_pos = {1'b0, start} + {1'b0, size};
        inside_win = ({1'b0, pos} >= {1'b0, start}) && ({1'b0, pos} < end_pos);
    endfunction

    function automatic logic [31:0] pack_pair(input aiw_pkg::aiw_pair_type p);
        pack_pair = `AIW_WORD_ZERO;
        pack_pair[`AIW_VERT_MSB:`AIW_VERT_LSB]   = p.vert;
        pack_pair[`AIW_HORIZ_MSB:`AIW_HORIZ_LSB] = p.horiz;
    endfunction

    function automatic aiw_pkg::aiw_pair_type unpack_pair(input logic [31:0] w);
        unpack_pair.vert  = w[`AIW_VERT_MSB:`AIW_VERT_LSB];
        unpack_pair.horiz = w[`AIW_HORIZ_MSB:`AIW_HORIZ_LSB];
    endfunction

    aiw_fifo #(
        .WIDTH (`AIW_BYTE_W),
        .DEPTH (`AIW_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .in_data_i   (anc_data_i),
        .in_valid_i  (anc_valid_i),
        .in_ready_o  (anc_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    // ----------------------------------------
    // Region compare
    // ----------------------------------------
    always_comb begin
        top_h_hit = !field_i
                 && inside_win(st_r.line_cnt, st_r.tha_start.vert, st_r.tha_size.vert)
                 && inside_win(st_r.pix_cnt, st_r.tha_start.horiz, st_r.tha_size.horiz);
        bot_h_hit = field_i
                 && inside_win(st_r.line_cnt, st_r.bha_start.vert, st_r.bha_size.vert)
                 && inside_win(st_r.pix_cnt, st_r.bha_start.horiz, st_r.bha_size.horiz);
        top_v_hit = !field_i
                 && inside_win(st_r.line_cnt, st_r.tva_start.vert, st_r.tva_size.vert)
                 && inside_win(st_r.pix_cnt, st_r.tva_start.horiz, st_r.tva_size.horiz);
        in_region = top_h_hit || bot_h_hit || top_v_hit;
    end

    // Stall the FIFO outside regions so it fills and pushes back
    assign fifo_pop = pix_adv_i && in_region;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.out_valid = 1'b0;

        if (frame_start_i) begin
            st_nxt.line_cnt = `AIW_LINE_FIRST;
            st_nxt.pix_cnt  = `AIW_PIX_FIRST;
        end else if (line_start_i) begin
            st_nxt.line_cnt = st_r.line_cnt + 11'h001;
            st_nxt.pix_cnt  = `AIW_PIX_FIRST;
        end else if (pix_adv_i) begin
            st_nxt.pix_cnt = st_r.pix_cnt + 11'h001;
        end

        if (pix_adv_i) begin
            st_nxt.out_valid = 1'b1;
            st_nxt.out_anc   = in_region && fifo_valid;
            st_nxt.out_data  = (in_region && fifo_valid) ? fifo_data : video_data_i;
        end

        // Register writes; reserved bits are simply not stored
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `AIW_OFF_THA_START: st_nxt.tha_start = unpack_pair(reg_wdata_i);
                `AIW_OFF_THA_SIZE:  st_nxt.tha_size  = unpack_pair(reg_wdata_i);
                `AIW_OFF_BHA_START: st_nxt.bha_start = unpack_pair(reg_wdata_i);
                `AIW_OFF_BHA_SIZE:  st_nxt.bha_size  = unpack_pair(reg_wdata_i);
                `AIW_OFF_TVA_START: st_nxt.tva_start = unpack_pair(reg_wdata_i);
                `AIW_OFF_TVA_SIZE:  st_nxt.tva_size  = unpack_pair(reg_wdata_i);
                default: ;
            endcase
        end

        // Reads: data in next cycle, unmapped reads zero
        st_nxt.rdata = `AIW_WORD_ZERO;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `AIW_OFF_THA_START: st_nxt.rdata = pack_pair(st_r.tha_start);
                `AIW_OFF_THA_SIZE:  st_nxt.rdata = pack_pair(st_r.tha_size);
                `AIW_OFF_BHA_START: st_nxt.rdata = pack_pair(st_r.bha_start);
                `AIW_OFF_BHA_SIZE:  st_nxt.rdata = pack_pair(st_r.bha_size);
                `AIW_OFF_TVA_START: st_nxt.rdata = pack_pair(st_r.tva_start);
                `AIW_OFF_TVA_SIZE:  st_nxt.rdata = pack_pair(st_r.tva_size);
                `AIW_OFF_STATUS: begin
                    st_nxt.rdata = pack_pair('{vert: st_r.line_cnt, horiz: st_r.pix_cnt});
                    st_nxt.rdata[`AIW_UNDERRUN_BIT] = st_r.underrun;
                    st_nxt.underrun = 1'b0;
                end
                default: ;
            endcase
        end

        // Set wins over clear-on-read
        if (pix_adv_i && in_region && !fifo_valid) begin
            st_nxt.underrun = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_r          <= '0;
            st_r.line_cnt <= `AIW_LINE_FIRST;
            st_r.pix_cnt  <= `AIW_PIX_FIRST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign out_data_o  = st_r.out_data;
    assign out_valid_o = st_r.out_valid;
    assign out_anc_o   = st_r.out_anc;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    rsv_read_zero_a: assert property (
        reg_rd_i && reg_addr_i != `AIW_OFF_STATUS |=>
            reg_rdata_o[`AIW_RSV_HI_MSB:`AIW_RSV_HI_LSB] == 5'h00
            && reg_rdata_o[`AIW_RSV_LO_MSB:`AIW_RSV_LO_LSB] == 5'h00)
        else $error("reserved bits not zero");

    size_write_back_a: assert property (
        reg_wr_i && reg_addr_i == `AIW_OFF_BHA_SIZE |=>
            st_r.bha_size.vert == $past(reg_wdata_i[`AIW_VERT_MSB:`AIW_VERT_LSB])
            && st_r.bha_size.horiz == $past(reg_wdata_i[`AIW_HORIZ_MSB:`AIW_HORIZ_LSB]))
        else $error("size register did not take write");

    line_first_a: assert property (
        frame_start_i |=> st_r.line_cnt == `AIW_LINE_FIRST && st_r.pix_cnt == `AIW_PIX_FIRST)
        else $error("line counter not 1 after frame start");

    pix_first_a: assert property (
        line_start_i && !frame_start_i |=>
            st_r.pix_cnt == 11'h000 && st_r.line_cnt == $past(st_r.line_cnt) + 11'h001)
        else $error("pixel counter not restarted");

    bot_start_a: assert property (
        pix_adv_i && field_i && fifo_valid
            && st_r.line_cnt == st_r.bha_start.vert
            && st_r.pix_cnt == st_r.bha_start.horiz
            && st_r.bha_size.vert != `AIW_FIELD_RESET
            && st_r.bha_size.horiz != `AIW_FIELD_RESET
            |=> out_valid_o && out_anc_o)
        else $error("bottom region did not start");

    top_vert_a: assert property (
        pix_adv_i && !field_i && fifo_valid
            && st_r.line_cnt == st_r.tva_start.vert
            && st_r.pix_cnt == st_r.tva_start.horiz
            && st_r.tva_size.vert != `AIW_FIELD_RESET
            && st_r.tva_size.horiz != `AIW_FIELD_RESET
            |=> out_valid_o && out_anc_o)
        else $error("top vertical region did not start");

    field_split_a: assert property (
        pix_adv_i && field_i
            && !inside_win(st_r.line_cnt, st_r.bha_start.vert, st_r.bha_size.vert)
            |=> !out_anc_o)
        else $error("top settings used in bottom field");

    anc_inside_a: assert property (
        out_valid_o && out_anc_o |-> $past(in_region) && $past(fifo_valid)
            && $past(pix_adv_i))
        else $error("ancillary byte outside region");

    read_latency_a: assert property (
        reg_rd_i && reg_addr_i == `AIW_OFF_THA_START ##1 !reg_wr_i |->
            reg_rdata_o[`AIW_VERT_MSB:`AIW_VERT_LSB] == st_r.tha_start.vert)
        else $error("top start readback wrong");
endmodule
`default_nettype wire

// File: inc/aiw_consts.svh
// Purpose: Constants for the ancillary insertion window block
// Assumes: 32-bit register words, 8-bit register address
// Notes:   Included by bare name
`ifndef AIW_CONSTS_SVH
`define AIW_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define AIW_ADDR_W          8
`define AIW_OFF_THA_START   8'h00
`define AIW_OFF_THA_SIZE    8'h04
`define AIW_OFF_BHA_START   8'h08
`define AIW_OFF_BHA_SIZE    8'h0c
`define AIW_OFF_TVA_START   8'h10
`define AIW_OFF_TVA_SIZE    8'h14
`define AIW_OFF_STATUS      8'h18

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define AIW_VERT_MSB        26
`define AIW_VERT_LSB        16
`define AIW_HORIZ_MSB       10
`define AIW_HORIZ_LSB       0
`define AIW_RSV_HI_MSB      31
`define AIW_RSV_HI_LSB      27
`define AIW_RSV_LO_MSB      15
`define AIW_RSV_LO_LSB      11
`define AIW_UNDERRUN_BIT    31
`define AIW_FIELD_RESET     11'h000
`define AIW_LINE_FIRST      11'h001
`define AIW_PIX_FIRST       11'h000
`define AIW_DATA_RESET      8'h00
`define AIW_WORD_ZERO       32'h0000_0000
`define AIW_FIFO_DEPTH      16
`define AIW_BYTE_W          8

`endif

// File: inc/aiw_pkg.sv
// Purpose: Types for the ancillary insertion window block
// Assumes: aiw_consts.svh holds the numbers
// Notes:   Nothing is imported elsewhere
`include "aiw_consts.svh"

package aiw_pkg;

    // One placement register: line part and pixel part
    typedef struct packed {
        logic [10:0] vert;
        logic [10:0] horiz;
    } aiw_pair_type;

    typedef struct packed {
        aiw_pair_type tha_start;
        aiw_pair_type tha_size;
        aiw_pair_type bha_start;
        aiw_pair_type bha_size;
        aiw_pair_type tva_start;
        aiw_pair_type tva_size;
        logic [10:0]  line_cnt;
        logic [10:0]  pix_cnt;
        logic         underrun;
        logic [31:0]  rdata;
        logic [7:0]   out_data;
        logic         out_valid;
        logic         out_anc;
    } aiw_state_type;

endpackage

// File: verification/aiw_sink.sv
// Purpose: Far-side byte stream receiver model
// Assumes: One byte arrives per out_valid pulse
// Notes:   Keeps {ancillary flag, byte} in arrival order
`timescale 1ns/1ps
`default_nettype none
module aiw_sink (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] out_data_i,
    input  wire logic       out_valid_i,
    input  wire logic       out_anc_i
);
    // ----------------------------------------
    // Capture
    // ----------------------------------------
    logic [8:0] got_q[$];

    // No back-pressure: a real receiver cannot stall the stream
    always @(posedge clk_sys_i) begin
        if (out_valid_i === 1'b1) begin
            got_q.push_back({out_anc_i, out_data_i});
        end
    end
endmodule
`default_nettype wire

// File: verification/tb.sv
// Purpose: Self-checking bench for aiw_window
// Assumes: Offsets and field layout from aiw_consts.svh
// Notes:   Expected stream is built from the programmed windows
`timescale 1ns/1ps
`default_nettype none
`include "aiw_consts.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
    logic        clk_sys_i   = 1'b0;
    logic        reset_i     = 1'b1;
    logic [7:0]  reg_addr    = 8'h00;
    logic [31:0] reg_wdata   = 32'h0000_0000;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [31:0] reg_rdata;
    logic        frame_start = 1'b0;
    logic        line_start  = 1'b0;
    logic        pix_adv     = 1'b0;
    logic        field       = 1'b0;
    logic [7:0]  video_data  = 8'h00;
    logic [7:0]  anc_data    = 8'h00;
    logic        anc_valid   = 1'b0;
    logic        anc_ready;
    logic [7:0]  out_data;
    logic        out_valid;
    logic        out_anc;
    int          n_errors    = 0;
    int          checks      = 0;
    int          avail       = 0;
    logic [7:0]  push_val    = 8'ha0;
    logic [7:0]  pop_val     = 8'ha0;
    logic [31:0] cfg [6];
    logic [31:0] rv;
    logic [8:0]  exp_q[$];

    aiw_window u_aiw_window (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .frame_start_i(frame_start), .line_start_i(line_start), .pix_adv_i(pix_adv),
        .field_i(field), .video_data_i(video_data), .anc_data_i(anc_data),
        .anc_valid_i(anc_valid), .anc_ready_o(anc_ready), .out_data_o(out_data),
        .out_valid_o(out_valid), .out_anc_o(out_anc));
    aiw_sink u_aiw_sink (.clk_sys_i(clk_sys_i), .out_data_i(out_data),
        .out_valid_i(out_valid), .out_anc_i(out_anc));

    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    // ----------------------------------------
    // Bus and stream tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic bit in_rect(input logic [31:0] st, input logic [31:0] sz,
                                   input int l, input int p);
        return l >= st[26:16] && l < st[26:16] + sz[26:16]
            && p >= st[10:0] && p < st[10:0] + sz[10:0];
    endfunction

    // Push until the buffer refuses; it must hold exactly sixteen
    task automatic fill();
        int n = 0;
        @(posedge clk_sys_i);
        anc_valid <= 1'b1;
        anc_data  <= push_val;
        repeat (40) begin
            @(posedge clk_sys_i);
            if (anc_ready === 1'b1) begin
                n++;
                push_val = push_val + 8'h01;
                anc_data <= push_val;
            end
        end
        anc_valid <= 1'b0;
        avail += n;
        `CHK(n, `AIW_FIFO_DEPTH)
        `CHK(anc_ready, 1'b0)
    endtask

    task automatic frame(input logic f, input int nl, input int np);
        bit hit;
        logic [8:0] g;
        logic [8:0] e;
        @(posedge clk_sys_i);
        field       <= f;
        frame_start <= 1'b1;
        @(posedge clk_sys_i);
        frame_start <= 1'b0;
        for (int l = 1; l <= nl; l++) begin
            if (l > 1) begin
                pix_adv    <= 1'b0;
                line_start <= 1'b1;
                @(posedge clk_sys_i);
                line_start <= 1'b0;
            end
            for (int p = 0; p < np; p++) begin
                hit = f ? in_rect(cfg[2], cfg[3], l, p)
                        : in_rect(cfg[0], cfg[1], l, p) || in_rect(cfg[4], cfg[5], l, p);
                video_data <= 8'(l * 32 + p);
                pix_adv    <= 1'b1;
                if (hit && avail > 0) begin
                    exp_q.push_back({1'b1, pop_val});
                    pop_val = pop_val + 8'h01;
                    avail--;
                end else begin
                    exp_q.push_back({1'b0, 8'(l * 32 + p)});
                end
                @(posedge clk_sys_i);
            end
        end
        pix_adv <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        `CHK(u_aiw_sink.got_q.size(), exp_q.size())
        while (exp_q.size() > 0 && u_aiw_sink.got_q.size() > 0) begin
            g = u_aiw_sink.got_q.pop_front();
            e = exp_q.pop_front();
            `CHK(g, e)
        end
        exp_q.delete();
        u_aiw_sink.got_q.delete();
    endtask

    task automatic results();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), rv);
            `CHK(rv, `AIW_WORD_ZERO)
            wr(8'(i * 4), 32'hffff_ffff);
            rd(8'(i * 4), rv);
            `CHK(rv, 32'h07ff_07ff)
        end
        rd(8'h1c, rv);
        `CHK(rv, `AIW_WORD_ZERO)
        // pixel starts and widths in steps of eight
        cfg = '{32'h0002_0008, 32'h0001_0008, 32'h0003_0000,
                32'h0002_0008, 32'h0001_0010, 32'h0001_0008};
        for (int i = 0; i < 6; i++) begin
            wr(8'(i * 4), cfg[i]);
        end
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), rv);
            `CHK(rv, cfg[i])
        end
        fill();
        frame(1'b0, 5, 24);
        rd(`AIW_OFF_STATUS, rv);
        `CHK(rv, 32'h0005_0018)
        fill();
        frame(1'b1, 5, 24);
        // Empty buffer inside a window sends video instead
        frame(1'b1, 5, 24);
        rd(`AIW_OFF_STATUS, rv);
        `CHK(rv[31], 1'b1)
        rd(`AIW_OFF_STATUS, rv);
        `CHK(rv[31], 1'b0)
        results();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        results();
    end
endmodule
`default_nettype wire
